//--- sir_pkg.sv
`default_nettype none
package sir_pkg;
   // Register word indices; byte address is four times the index
   localparam logic [3:0] IDX_CTRL = 4'h0;
   localparam logic [3:0] IDX_RSTS = 4'h1;
   localparam logic [3:0] IDX_SCR0 = 4'h2;
   localparam logic [3:0] IDX_SCR3 = 4'h5;
   localparam logic [3:0] IDX_IDHI = 4'h6;
   localparam logic [3:0] IDX_IDLO = 4'h7;
   localparam logic [3:0] IDX_PUD = 4'h8;
   localparam logic [3:0] IDX_CLKO = 4'ha;
   localparam logic [3:0] IDX_GPS = 4'hb;
   localparam logic [3:0] IDX_PCE = 4'hc;
   localparam logic [3:0] IDX_ISALH = 4'hd;
   localparam logic [3:0] IDX_ISALL = 4'he;
   // Control field positions
   localparam int CTRL_DBG_BIT = 5;
   localparam int CTRL_SRST_BIT = 4;
   localparam int CTRL_STOP_LSB = 2;
   localparam int CTRL_WAIT_LSB = 0;
   // Reset-cause flags sit at bits 5:2; index within the flag group
   localparam int RSTS_LSB = 2;
   localparam int FLG_POR = 0;
   localparam int FLG_PIN = 1;
   localparam int FLG_WDOG = 2;
   localparam int FLG_SOFT = 3;
   localparam logic [3:0] FLAGS_POR_RST = 4'h1;
   // Implemented-bit masks
   localparam logic [15:0] PUD_MASK = 16'h0c08;
   localparam logic [15:0] CLKO_MASK = 16'h03ff;
   localparam logic [15:0] GPS_MASK = 16'h00ff;
   localparam logic [15:0] PCE_MASK = 16'h357c;
   localparam logic [15:0] ISALH_MASK = 16'h0003;
   // Reset values of the implemented bits
   localparam logic [15:0] PUD_RST = 16'h0000;
   localparam logic [15:0] CLKO_RST = 16'h0020;
   localparam logic [15:0] GPS_RST = 16'h0000;
   localparam logic [15:0] PCE_RST = 16'h0000;
   localparam logic [15:0] SAB_RST = 16'h0000;
   localparam logic [15:0] SCR_RST = 16'h0000;
   // Identification words, values arbitrary
   localparam logic [15:0] ID_UPPER_DEF = 16'h0a5a;
   localparam logic [15:0] ID_LOWER_DEF = 16'h0c3c;
   // Soft reset pulse length
   localparam int MCLK_NS = 8;
   localparam int SRST_NS = 128;
   localparam int SRST_CYC = (SRST_NS + MCLK_NS - 1) / MCLK_NS;
   // Soft reset sequencer states
   typedef enum logic [1:0] {
      SR_IDLE = 2'b01,
      SR_HOLD = 2'b10
   } sir_srst_t;
   // Merge write data into a word under the two low byte enables
   function automatic logic [15:0] sir_merge(input logic [15:0] old_v,
         input logic [15:0] new_v, input logic [1:0] be);
      logic [15:0] r;
      r = old_v;
      if (be[0]) begin
         r[7:0] = new_v[7:0];
      end
      if (be[1]) begin
         r[15:8] = new_v[15:8];
      end
      return r;
   endfunction
endpackage
`default_nettype wire

//--- sir_bus_if.sv
`timescale 1ns/1ps
`default_nettype none
// Internal register access channel
interface sir_bus_if;
   logic wr_stb;
   logic [3:0] idx;
   logic [15:0] wdata;
   logic [1:0] be;
   logic [15:0] rdata;
   modport drv(output wr_stb, output idx, output wdata, output be,
      input rdata);
   modport regs(input wr_stb, input idx, input wdata, input be,
      output rdata);
   modport obs(input wr_stb, input idx, input wdata, input be);
endinterface
`default_nettype wire

//--- sir_avs.sv
`timescale 1ns/1ps
`default_nettype none
module sir_avs (
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic [5:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   sir_bus_if.drv bus
);
   import sir_pkg::*;
   typedef struct packed {
      logic ack;
      logic [15:0] rdata;
   } sir_avs_st_t;
   sir_avs_st_t st_r, st_nxt;

   ////////////////////////////////////////////////////////////////////
   // One wait cycle: sample read data, then release waitrequest
   always_comb begin
      st_nxt = st_r;
      st_nxt.ack = 1'b0;
      if ((avs_read || avs_write) && !st_r.ack) begin
         st_nxt.ack = 1'b1;
         if (avs_read) begin
            st_nxt.rdata = bus.rdata;
         end
      end
   end

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Writes take effect on the edge where waitrequest is low
   assign avs_waitrequest = (avs_read || avs_write) && !st_r.ack;
   assign bus.wr_stb = avs_write && st_r.ack;
   assign bus.idx = avs_address[5:2];
   assign bus.wdata = avs_writedata[15:0];
   assign bus.be = avs_byteenable[1:0];
   assign avs_readdata = {16'h0000, st_r.rdata}; // Upper lanes read zero
endmodule
`default_nettype wire

//--- sir_rst_cause.sv
`timescale 1ns/1ps
`default_nettype none
module sir_rst_cause (
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic pin_reset,
   input wire logic watchdog_reset,
   input wire logic soft_reset_active,
   output logic [3:0] flags,
   sir_bus_if.obs bus
);
   import sir_pkg::*;
   typedef struct packed {
      logic [3:0] flags;
   } sir_rc_st_t;
   sir_rc_st_t st_r, st_nxt;
   logic [15:0] wr_img;
   logic [3:0] set_m;
   logic [3:0] clr_m;

   ////////////////////////////////////////////////////////////////////
   // Inverted write, then hardware sets win over any clear
   always_comb begin
      st_nxt = st_r;
      wr_img = sir_merge({10'h000, st_r.flags, 2'b00}, ~bus.wdata,
         bus.be);
      set_m = '0;
      clr_m = '0;
      if (bus.wr_stb && bus.idx == IDX_RSTS) begin
         st_nxt.flags = wr_img[RSTS_LSB +: 4];
      end
      // Flags follow their source while it is active
      if (pin_reset) begin
         set_m[FLG_PIN] = 1'b1;
      end
      if (watchdog_reset) begin
         set_m[FLG_WDOG] = 1'b1;
      end
      if (soft_reset_active) begin
         set_m[FLG_SOFT] = 1'b1;
      end
      if (pin_reset || watchdog_reset || soft_reset_active) begin
         clr_m[FLG_POR] = 1'b1;
      end
      if (pin_reset || watchdog_reset) begin
         clr_m[FLG_SOFT] = 1'b1;
      end
      st_nxt.flags = (st_nxt.flags & ~clr_m) | set_m;
   end

   // Only power-on reset initialises the flags
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         st_r.flags <= FLAGS_POR_RST;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign flags = st_r.flags;
endmodule
`default_nettype wire

//--- sir_regs.sv
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - Control bits 15..6 read zero, ignore writes
// - Control bit 5 forces debug clock on
// - Writing a one to control bit 4 triggers software reset
// - Stop field 00 allows, 01 blocks rewritably
// - Stop field 1x blocks and locks until reset
// - Wait field 00 allows, 01 blocks rewritably
// - Wait field 1x blocks and locks until reset
// - Only power-on initialises flags; others set own
// - Status bit 5 marks software reset
// - Software flag cleared by hardware reset, software
// - Cause flags: write 0 sets, 1 clears
// - Status bit 4 marks watchdog reset
// - Status bit 3 marks reset pin reset
// - Status bit 2 marks power-on reset
// - Status bits 15..6, 1..0 read zero
// - Four general 16-bit read/write software words
// - Two read-only identification halves ignore writes
// - Clock enable register, unused bits read one
// - Short address base split, high unused read one
// - Pin select: eight bits, upper bits zero
// - Software words reset by power-on only
module sir_regs #(
   parameter logic [15:0] ID_UPPER = sir_pkg::ID_UPPER_DEF,
   parameter logic [15:0] ID_LOWER = sir_pkg::ID_LOWER_DEF,
   parameter int SRST_CYC = sir_pkg::SRST_CYC
) (
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic [5:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic pin_reset,
   input wire logic watchdog_reset,
   input wire logic tap_enabled,
   input wire logic core_stop_req,
   input wire logic core_wait_req,
   output logic debug_clock_en,
   output logic stop_entry,
   output logic wait_entry,
   output logic soft_reset_out,
   output logic [15:0] pullup_disable_bits,
   output logic [15:0] clock_output_bits,
   output logic [15:0] pin_select_bits,
   output logic [15:0] periph_clk_en,
   output logic [17:0] short_address_base
);
   import sir_pkg::*;

   localparam int CW = $clog2(SRST_CYC + 1);
   localparam logic [CW-1:0] SRST_LAST = CW'(SRST_CYC - 1);

   // Software word slot from a word index
   function automatic logic [1:0] scr_slot(input logic [3:0] idx);
      return 2'(idx - IDX_SCR0);
   endfunction

   // Unused positions read as one
   function automatic logic [15:0] ones_fill(input logic [15:0] v,
         input logic [15:0] mask);
      return (v & mask) | ~mask;
   endfunction

   typedef struct packed {
      logic dbg;
      logic [1:0] stopc;
      logic [1:0] waitc;
      logic [3:0][15:0] scr;
      logic [15:0] pud;
      logic [15:0] clko;
      logic [15:0] gps;
      logic [15:0] pce;
      logic [15:0] isalh;
      logic [15:0] isall;
      sir_srst_t srst;
      logic [CW-1:0] scnt;
      logic dbg_out;
      logic stop_out;
      logic wait_out;
   } sir_regs_t;

   sir_regs_t st_r, st_nxt;
   sir_bus_if bus ();
   logic [3:0] flags;
   logic soft_active;
   logic sys_hw_rst;
   logic [15:0] ctrl_rd;
   logic [15:0] m;
   logic wr;
   logic srst_hit;

   ////////////////////////////////////////////////////////////////////
   // Bus slave and reset-cause flags
   sir_avs u_avs (
      .mclk(mclk),
      .sys_rst(sys_rst),
      .avs_address(avs_address),
      .avs_read(avs_read),
      .avs_write(avs_write),
      .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest),
      .bus(bus.drv)
   );

   sir_rst_cause u_cause (
      .mclk(mclk),
      .sys_rst(sys_rst),
      .pin_reset(pin_reset),
      .watchdog_reset(watchdog_reset),
      .soft_reset_active(soft_active),
      .flags(flags),
      .bus(bus.obs)
   );

   ////////////////////////////////////////////////////////////////////
   // Any non power-on system reset
   assign soft_active = (st_r.srst == SR_HOLD);
   assign sys_hw_rst = pin_reset || watchdog_reset || soft_active;
   // A one written to the trigger bit
   assign srst_hit = bus.wr_stb && bus.idx == IDX_CTRL && bus.be[0] &&
      bus.wdata[CTRL_SRST_BIT];

   // Control readback; trigger bit and upper bits read zero
   always_comb begin
      ctrl_rd = 16'h0000;
      ctrl_rd[CTRL_DBG_BIT] = st_r.dbg;
      ctrl_rd[CTRL_STOP_LSB +: 2] = st_r.stopc;
      ctrl_rd[CTRL_WAIT_LSB +: 2] = st_r.waitc;
   end

   ////////////////////////////////////////////////////////////////////
   // Read multiplexer
   always_comb begin
      case (bus.idx)
         IDX_CTRL: begin
            bus.rdata = ctrl_rd;
         end
         IDX_RSTS: begin
            bus.rdata = {10'h000, flags, 2'b00};
         end
         4'h2, 4'h3, 4'h4, IDX_SCR3: begin
            bus.rdata = st_r.scr[scr_slot(bus.idx)];
         end
         IDX_IDHI: begin
            bus.rdata = ID_UPPER;
         end
         IDX_IDLO: begin
            bus.rdata = ID_LOWER;
         end
         IDX_PUD: begin
            bus.rdata = st_r.pud & PUD_MASK;
         end
         IDX_CLKO: begin
            bus.rdata = st_r.clko & CLKO_MASK;
         end
         IDX_GPS: begin
            bus.rdata = st_r.gps & GPS_MASK;
         end
         IDX_PCE: begin
            bus.rdata = ones_fill(st_r.pce, PCE_MASK);
         end
         IDX_ISALH: begin
            bus.rdata = ones_fill(st_r.isalh, ISALH_MASK);
         end
         IDX_ISALL: begin
            bus.rdata = st_r.isall;
         end
         default: begin
            bus.rdata = 16'h0000;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////
   // Next-state logic for the register bank
   always_comb begin
      st_nxt = st_r;
      wr = bus.wr_stb && !sys_hw_rst;
      m = 16'h0000;
      case (bus.idx)
         IDX_CTRL: begin
            m = sir_merge(ctrl_rd, bus.wdata, bus.be);
         end
         IDX_PUD: begin
            m = sir_merge(st_r.pud, bus.wdata, bus.be) & PUD_MASK;
         end
         IDX_CLKO: begin
            m = sir_merge(st_r.clko, bus.wdata, bus.be) & CLKO_MASK;
         end
         IDX_GPS: begin
            m = sir_merge(st_r.gps, bus.wdata, bus.be) & GPS_MASK;
         end
         IDX_PCE: begin
            m = sir_merge(st_r.pce, bus.wdata, bus.be) & PCE_MASK;
         end
         IDX_ISALH: begin
            m = sir_merge(st_r.isalh, bus.wdata, bus.be) & ISALH_MASK;
         end
         IDX_ISALL: begin
            m = sir_merge(st_r.isall, bus.wdata, bus.be);
         end
         4'h2, 4'h3, 4'h4, IDX_SCR3: begin
            m = sir_merge(st_r.scr[scr_slot(bus.idx)], bus.wdata, bus.be);
         end
         default: begin
            m = 16'h0000;
         end
      endcase

      // Register writes; identification and status have none here
      if (wr) begin
         case (bus.idx)
            IDX_CTRL: begin
               st_nxt.dbg = m[CTRL_DBG_BIT];
               // A field holding 1x stays locked until reset
               if (!st_r.stopc[1]) begin
                  st_nxt.stopc = m[CTRL_STOP_LSB +: 2];
               end
               if (!st_r.waitc[1]) begin
                  st_nxt.waitc = m[CTRL_WAIT_LSB +: 2];
               end
               if (srst_hit) begin
                  st_nxt.srst = SR_HOLD;
                  st_nxt.scnt = SRST_LAST;
               end
            end
            IDX_PUD: begin
               st_nxt.pud = m;
            end
            IDX_CLKO: begin
               st_nxt.clko = m;
            end
            IDX_GPS: begin
               st_nxt.gps = m;
            end
            IDX_PCE: begin
               st_nxt.pce = m;
            end
            IDX_ISALH: begin
               st_nxt.isalh = m;
            end
            IDX_ISALL: begin
               st_nxt.isall = m;
            end
            4'h2, 4'h3, 4'h4, IDX_SCR3: begin
               st_nxt.scr[scr_slot(bus.idx)] = m;
            end
            default: begin
               st_nxt.dbg = st_r.dbg;
            end
         endcase
      end

      // Soft reset pulse sequencer
      case (st_r.srst)
         SR_IDLE: begin
            st_nxt.scnt = (st_nxt.srst == SR_HOLD) ? SRST_LAST : '0;
         end
         SR_HOLD: begin
            if (st_r.scnt == '0) begin
               st_nxt.srst = SR_IDLE;
            end else begin
               st_nxt.scnt = st_r.scnt - 1'b1;
            end
         end
         default: begin
            st_nxt.srst = SR_IDLE;
            st_nxt.scnt = '0;
         end
      endcase

      // Other system resets clear control and map, not software words
      if (sys_hw_rst) begin
         st_nxt.dbg = 1'b0;
         st_nxt.stopc = 2'b00;
         st_nxt.waitc = 2'b00;
         st_nxt.pud = PUD_RST;
         st_nxt.clko = CLKO_RST;
         st_nxt.gps = GPS_RST;
         st_nxt.pce = PCE_RST;
         st_nxt.isalh = SAB_RST;
         st_nxt.isall = SAB_RST;
         // Software words keep their value
      end

      // Registered block outputs
      st_nxt.dbg_out = st_r.dbg || tap_enabled;
      st_nxt.stop_out = core_stop_req && (st_r.stopc == 2'b00);
      st_nxt.wait_out = core_wait_req && (st_r.waitc == 2'b00);
   end

   ////////////////////////////////////////////////////////////////////
   // State register; power-on reset initialises everything
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         st_r.dbg <= 1'b0;
         st_r.stopc <= 2'b00;
         st_r.waitc <= 2'b00;
         st_r.scr <= {4{SCR_RST}};
         st_r.pud <= PUD_RST;
         st_r.clko <= CLKO_RST;
         st_r.gps <= GPS_RST;
         st_r.pce <= PCE_RST;
         st_r.isalh <= SAB_RST;
         st_r.isall <= SAB_RST;
         st_r.srst <= SR_IDLE;
         st_r.scnt <= '0;
         st_r.dbg_out <= 1'b0;
         st_r.stop_out <= 1'b0;
         st_r.wait_out <= 1'b0;
      end else begin
         st_r <= st_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Outputs
   // Core controls, from flip-flops
   assign debug_clock_en = st_r.dbg_out;
   assign stop_entry = st_r.stop_out;
   assign wait_entry = st_r.wait_out;
   // Soft reset pulse from the sequencer
   assign soft_reset_out = soft_active;
   // Pin and clock map
   assign pullup_disable_bits = st_r.pud;
   assign clock_output_bits = st_r.clko;
   assign pin_select_bits = st_r.gps;
   // Clock enables and short address base
   assign periph_clk_en = ones_fill(st_r.pce, PCE_MASK);
   assign short_address_base = {st_r.isalh[1:0], st_r.isall};
endmodule
`default_nettype wire

//--- sir_regs_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module sir_regs_monitor #(
   parameter int SRST_CYC = sir_pkg::SRST_CYC
) (
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic [5:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   input wire logic tap_enabled,
   input wire logic core_stop_req,
   input wire logic core_wait_req,
   input wire logic debug_clock_en,
   input wire logic stop_entry,
   input wire logic wait_entry,
   input wire logic soft_reset_out,
   input wire logic [15:0] pin_select_bits,
   input wire logic [15:0] periph_clk_en
);
   import sir_pkg::*;
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (sys_rst);
   logic [7:0] hi_cnt_r;
   logic [7:0] hi_cnt_nxt;
   logic rd_ack;
   logic go_srst;
   logic [3:0] widx;
   ////////////////////////////////////////////////////////////////////////
   // Accepted transfers and soft reset pulse length
   assign widx = avs_address[5:2];
   assign rd_ack = avs_read && !avs_waitrequest;
   assign go_srst = avs_write && !avs_waitrequest && widx == IDX_CTRL &&
      avs_byteenable[0] && avs_writedata[4];
   assign hi_cnt_nxt = soft_reset_out ? hi_cnt_r + 8'h01 : 8'h00;
   // Counts high cycles of the pulse
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         hi_cnt_r <= 8'h00;
      end else begin
         hi_cnt_r <= hi_cnt_nxt;
      end
   end
   ////////////////////////////////////////////////////////////////////////
   bus_wait_a: assert property ($rose(avs_read | avs_write) |->
      avs_waitrequest ##1 !avs_waitrequest)
      else $error("bus answer not after exactly one wait");
   ctrl_zero_a: assert property (rd_ack && widx == IDX_CTRL |->
      avs_readdata[31:6] == 26'h0000000)
      else $error("control upper bits not zero");
   rsts_zero_a: assert property (rd_ack && widx == IDX_RSTS |->
      avs_readdata[15:6] == 10'h000 && avs_readdata[1:0] == 2'h0)
      else $error("status unused bits not zero");
   id_value_a: assert property (rd_ack && widx == IDX_IDHI |->
      avs_readdata[15:0] == ID_UPPER_DEF)
      else $error("upper id half wrong");
   dbg_clock_a: assert property (!$past(sys_rst) && tap_enabled
      |=> debug_clock_en)
      else $error("debug clock off while test port enabled");
   stop_cause_a: assert property (stop_entry |->
      $past(core_stop_req))
      else $error("stop entry without request");
   wait_cause_a: assert property (wait_entry |->
      $past(core_wait_req))
      else $error("wait entry without request");
   srst_start_a: assert property (go_srst |->
      ##[1:2] soft_reset_out)
      else $error("soft reset did not start");
   srst_len_a: assert property ($fell(soft_reset_out) |->
      hi_cnt_r == SRST_CYC)
      else $error("soft reset pulse length wrong");
   pce_ones_a: assert property ((periph_clk_en & ~PCE_MASK) ==
      ~PCE_MASK)
      else $error("clock enable unused bits not one");
   gps_upper_a: assert property (pin_select_bits[15:8] == 8'h00)
      else $error("pin select upper bits not zero");
   soft_rst_c: cover property ($fell(soft_reset_out));
   stop_c: cover property (stop_entry && wait_entry);
   read_c: cover property (rd_ack && widx == IDX_RSTS);
endmodule
`default_nettype wire

//--- sir_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module sir_host_model (
   input wire logic mclk,
   output logic [5:0] avs_address,
   output logic avs_read,
   output logic avs_write,
   output logic [31:0] avs_writedata,
   output logic [3:0] avs_byteenable,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest
);
   // Idle bus at time zero
   initial begin
      avs_address = 6'h00;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h00000000;
      avs_byteenable = 4'h0;
   end
   ////////////////////////////////////////////////////////////////////////
   // Write held until the slave stops waiting, then lines scrambled
   task automatic wr(input logic [3:0] idx, input logic [15:0] v,
         input logic [1:0] be = 2'b11);
      @(posedge mclk);
      avs_address <= {idx, 2'b00};
      avs_writedata <= {16'h0000, v};
      avs_byteenable <= {2'b00, be};
      avs_write <= 1'b1;
      do @(posedge mclk); while (avs_waitrequest !== 1'b0);
      avs_write <= 1'b0;
      avs_writedata <= ~avs_writedata;
      avs_address <= ~avs_address;
   endtask
   // Read; data taken at the edge that ends the wait
   task automatic rd(input logic [3:0] idx, output logic [15:0] v);
      @(posedge mclk);
      avs_address <= {idx, 2'b00};
      avs_read <= 1'b1;
      do @(posedge mclk); while (avs_waitrequest !== 1'b0);
      v = avs_readdata[15:0];
      avs_read <= 1'b0;
      avs_address <= ~avs_address;
   endtask
endmodule
`default_nettype wire

//--- test_system_integration_regs.sv
`timescale 1ns/1ps
`default_nettype none
module test_system_integration_regs;
   import sir_pkg::*;
   localparam int SRST_CYC = 2;
   logic mclk = 1'b0;
   logic sys_rst = 1'b1;
   logic pin_reset = 1'b0;
   logic watchdog_reset = 1'b0;
   logic tap_enabled = 1'b0;
   logic core_stop_req = 1'b0;
   logic core_wait_req = 1'b0;
   logic [5:0] adr;
   logic rdq;
   logic wrq;
   logic [31:0] wdat;
   logic [3:0] be;
   logic [31:0] rdat;
   logic wreq;
   logic dbg;
   logic stop_e;
   logic wait_e;
   logic srst;
   logic [15:0] gps;
   logic [15:0] pud;
   logic [15:0] clko;
   logic [15:0] pce;
   logic [17:0] sab;
   logic [15:0] d;
   int bad_count = 0;
   int samples_checked = 0;
   always #4 mclk = ~mclk;
   sir_host_model host (.mclk(mclk), .avs_address(adr), .avs_read(rdq),
      .avs_write(wrq), .avs_writedata(wdat), .avs_byteenable(be),
      .avs_readdata(rdat), .avs_waitrequest(wreq));
   sir_regs #(.SRST_CYC(SRST_CYC)) uut (.mclk(mclk), .sys_rst(sys_rst),
      .avs_address(adr), .avs_read(rdq), .avs_write(wrq),
      .avs_writedata(wdat), .avs_byteenable(be), .avs_readdata(rdat),
      .avs_waitrequest(wreq), .pin_reset(pin_reset),
      .watchdog_reset(watchdog_reset), .tap_enabled(tap_enabled),
      .core_stop_req(core_stop_req), .core_wait_req(core_wait_req),
      .debug_clock_en(dbg), .stop_entry(stop_e), .wait_entry(wait_e),
      .soft_reset_out(srst), .pullup_disable_bits(pud),
      .clock_output_bits(clko), .pin_select_bits(gps), .periph_clk_en(pce),
      .short_address_base(sab));
   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp);
      end
   endtask
   task automatic rchk(input logic [3:0] idx, input logic [15:0] exp);
      host.rd(idx, d);
      chk({16'h0000, d}, {16'h0000, exp});
   endtask
   // Core executes stop and wait together; expv is {stop, wait}
   task automatic pulse(input logic [1:0] expv);
      @(posedge mclk);
      core_stop_req <= 1'b1;
      core_wait_req <= 1'b1;
      @(posedge mclk);
      core_stop_req <= 1'b0;
      core_wait_req <= 1'b0;
      @(negedge mclk);
      chk({30'h0, stop_e, wait_e}, {30'h0, expv});
   endtask
   task automatic hw_rst(input logic wd);
      @(posedge mclk);
      pin_reset <= !wd;
      watchdog_reset <= wd;
      repeat (3) @(posedge mclk);
      pin_reset <= 1'b0;
      watchdog_reset <= 1'b0;
      repeat (2) @(posedge mclk);
   endtask
   ////////////////////////////////////////////////////////////////////////
   task automatic t_reset_map();
      rchk(IDX_CTRL, 16'h0000);
      rchk(IDX_RSTS, 16'h0004);
      rchk(IDX_IDHI, ID_UPPER_DEF);
      rchk(IDX_IDLO, ID_LOWER_DEF);
      rchk(IDX_PCE, 16'hca83);
      rchk(IDX_ISALH, 16'hfffc);
      rchk(IDX_PUD, 16'h0000);
      rchk(IDX_CLKO, 16'h0020);
      rchk(4'hf, 16'h0000);
   endtask
   task automatic t_masks();
      host.wr(IDX_CTRL, 16'hffe5);
      rchk(IDX_CTRL, 16'h0025);
      chk({31'h0, dbg}, 32'h1);
      host.wr(IDX_IDHI, 16'h0000);
      rchk(IDX_IDHI, ID_UPPER_DEF);
      host.wr(IDX_RSTS, 16'hffc3);
      rchk(IDX_RSTS, 16'h003c);
      host.wr(IDX_RSTS, 16'hffff);
      rchk(IDX_RSTS, 16'h0000);
      host.wr(IDX_PCE, 16'h0000);
      rchk(IDX_PCE, 16'hca83);
      host.wr(IDX_PCE, 16'hffff);
      host.wr(IDX_GPS, 16'hffff);
      rchk(IDX_GPS, 16'h00ff);
      host.wr(IDX_PUD, 16'hffff);
      host.wr(IDX_CLKO, 16'hffff);
      rchk(IDX_PUD, 16'h0c08);
      rchk(IDX_CLKO, 16'h03ff);
      chk({pud, clko}, 32'h0c0803ff);
      chk({gps, pce}, 32'h00ffffff);
      host.wr(IDX_ISALH, 16'h0002);
      host.wr(IDX_ISALL, 16'h1234);
      rchk(IDX_ISALH, 16'hfffe);
      chk({14'h0, sab}, {14'h0, 18'h21234});
      for (int i = 0; i < 4; i++) begin
         host.wr(4'(IDX_SCR0 + i), 16'(16'h1111 * (i + 1)));
      end
      host.wr(IDX_SCR0, 16'h55ee, 2'b01);
      rchk(IDX_SCR0, 16'h11ee);
   endtask
   task automatic t_modes();
      host.wr(IDX_CTRL, 16'h0000);
      pulse(2'b11);
      chk({31'h0, dbg}, 32'h0);
      @(posedge mclk);
      tap_enabled <= 1'b1;
      repeat (2) @(negedge mclk);
      chk({31'h0, dbg}, 32'h1);
      @(posedge mclk);
      tap_enabled <= 1'b0;
      host.wr(IDX_CTRL, 16'h0005);
      pulse(2'b00);
      host.wr(IDX_CTRL, 16'h000a);
      host.wr(IDX_CTRL, 16'h0000);
      rchk(IDX_CTRL, 16'h000a);
      pulse(2'b00);
   endtask
   task automatic t_resets();
      hw_rst(1'b0);
      rchk(IDX_RSTS, 16'h0008);
      chk({pce, clko}, 32'hca830020);
      host.wr(IDX_CTRL, 16'h000f);
      host.wr(IDX_CTRL, 16'h0000);
      rchk(IDX_CTRL, 16'h000f);
      pulse(2'b00);
      host.wr(IDX_CTRL, 16'h0010);
      for (int n = 0; n < 8 && srst !== 1'b1; n++) @(negedge mclk);
      chk({31'h0, srst}, 32'h1);
      repeat (SRST_CYC + 4) @(posedge mclk);
      rchk(IDX_RSTS, 16'h0028);
      rchk(IDX_CTRL, 16'h0000);
      hw_rst(1'b1);
      rchk(IDX_RSTS, 16'h0018);
      rchk(IDX_SCR0, 16'h11ee);
      for (int i = 1; i < 4; i++) begin
         rchk(4'(IDX_SCR0 + i), 16'(16'h1111 * (i + 1)));
      end
      @(posedge mclk);
      sys_rst <= 1'b1;
      repeat (4) @(posedge mclk);
      sys_rst <= 1'b0;
      rchk(IDX_RSTS, 16'h0004);
      rchk(IDX_SCR3, SCR_RST);
   endtask
   ////////////////////////////////////////////////////////////////////////
   task automatic complete_run();
      if (bad_count == 0 && samples_checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   // Main sequence
   initial begin
      repeat (4) @(posedge mclk);
      sys_rst <= 1'b0;
      t_reset_map();
      t_masks();
      t_modes();
      t_resets();
      complete_run();
   end
   // Watchdog against a hung handshake
   initial begin
      #100000;
      bad_count++;
      complete_run();
   end
endmodule
bind sir_regs sir_regs_monitor #(.SRST_CYC(SRST_CYC)) mon (
   .mclk(mclk), .sys_rst(sys_rst), .avs_address(avs_address),
   .avs_read(avs_read), .avs_write(avs_write),
   .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
   .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
   .tap_enabled(tap_enabled), .core_stop_req(core_stop_req),
   .core_wait_req(core_wait_req), .debug_clock_en(debug_clock_en),
   .stop_entry(stop_entry), .wait_entry(wait_entry),
   .soft_reset_out(soft_reset_out), .pin_select_bits(pin_select_bits),
   .periph_clk_en(periph_clk_en));
`default_nettype wire
